//--- verilog/dtf_pkg.sv
// dtf_pkg: shared constants and types for the display text and reading formatter
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package dtf_pkg;
   localparam int MSG_LEN = 32;
   localparam logic [7:0] CHR_SPACE = 8'h20;
   localparam logic [7:0] CHR_HASH = 8'h23;
   localparam logic [7:0] CHR_ZERO = 8'h30;
   localparam logic [7:0] TERM_RST = 8'h0A;
   // reading format selections
   localparam logic [1:0] FMT_ASCII = 2'h0;
   localparam logic [1:0] FMT_SINGLE = 2'h1;
   localparam logic [1:0] FMT_DOUBLE = 2'h2;
   localparam logic [1:0] FMT_RST = 2'h0;
   localparam logic ORDER_SWAP_RST = 1'b1;
   localparam logic DISP_EN_RST = 1'b1;
   localparam logic TEXT_ON_RST = 1'b0;
   // single layout: sign, 8 exponent, 23 fraction; double: sign, 11, 52
   localparam int SGL_EXP_W = 8;
   localparam int SGL_FRAC_W = 23;
   localparam int DBL_EXP_W = 11;
   localparam int DBL_FRAC_W = 52;
   localparam logic [3:0] SGL_BYTES = 4'h4;
   localparam logic [3:0] DBL_BYTES = 4'h8;
   localparam logic [1:0] HDR_BYTES = 2'h2;
   typedef enum logic [2:0] {st_idle, st_hdr, st_elem, st_wait, st_term} dtf_state_e;
endpackage : dtf_pkg
`default_nettype wire

//--- verilog/dtf_msg_store.sv
// dtf_msg_store: 32-character user message store with space padding
// assumes writes arrive one character at a time from the command parser
`timescale 1ns/10ps
`default_nettype none
module dtf_msg_store
   import dtf_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // message load
   input wire logic load_start,
   input wire logic load_char_vld,
   input wire logic [7:0] load_char,
   input wire logic load_end,
   input wire logic clear,
   // read port
   input wire logic [4:0] rd_idx,
   output logic [7:0] rd_char,
   output logic too_long
);
   logic [7:0] mem_r [MSG_LEN];
   logic [5:0] wr_cnt_r;
   logic loading_r;
   logic too_long_r;

   // fill, blank on load start, clear or power-up
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < MSG_LEN; i++) mem_r[i] <= CHR_SPACE;
      end else if (clear || load_start) begin
         for (int i = 0; i < MSG_LEN; i++) mem_r[i] <= CHR_SPACE;
      end else if (loading_r && load_char_vld && wr_cnt_r < 6'(MSG_LEN)) begin
         mem_r[wr_cnt_r[4:0]] <= load_char;
      end
   end

   // count characters and track overflow
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wr_cnt_r <= 6'h00;
         loading_r <= 1'b0;
         too_long_r <= 1'b0;
      end else if (clear) begin
         wr_cnt_r <= 6'h00;
         loading_r <= 1'b0;
         too_long_r <= 1'b0;
      end else if (load_start) begin
         wr_cnt_r <= 6'h00;
         loading_r <= 1'b1;
         too_long_r <= 1'b0;
      end else begin
         if (loading_r && load_char_vld) begin
            if (wr_cnt_r == 6'(MSG_LEN)) too_long_r <= 1'b1;
            else wr_cnt_r <= wr_cnt_r + 6'h01;
         end
         if (load_end) loading_r <= 1'b0;
      end
   end

   assign rd_char = mem_r[rd_idx];
   assign too_long = too_long_r;
endmodule // dtf_msg_store
`default_nettype wire

//--- verilog/dtf_byte_sel.sv
// dtf_byte_sel: picks one byte of a reading element in normal or reversed order
// assumes the element is held stable while bytes are taken
`timescale 1ns/10ps
`default_nettype none
module dtf_byte_sel
   import dtf_pkg::*;
(
   // element and selection
   input wire logic [63:0] elem,
   input wire logic dbl,
   input wire logic swap,
   input wire logic [2:0] idx,
   // selected byte
   output logic [7:0] byte_out
);
   logic [2:0] pos;
   logic [2:0] last;

   // byte 0 is the most significant byte of the element
   always_comb begin
      last = dbl ? 3'h7 : 3'h3;
      pos = swap ? (last - idx) : idx;
      if (dbl) byte_out = elem[8'(63 - 8 * int'(pos)) -: 8];
      else byte_out = elem[8'(31 - 8 * int'(pos)) -: 8];
   end
endmodule // dtf_byte_sel
`default_nettype wire

//--- verilog/dtf_top.sv
// dtf_top: display enable, user text message and reading output formatter
// assumes a command parser upstream that decodes ASCII commands into strobes
// and a talker that takes bytes whenever out_ready is high
`timescale 1ns/10ps
`default_nettype none
// Operation
// - display enable command: 0 turns display off, 1 turns it on.
// - while display off, show blank and ignore panel keys except local.
// - display resumes on enable command or on entering local.
// - user message is 32 characters, top line wrapping to bottom.
// - short message padded with spaces to full length.
// - message over 32 characters is not shown.
// - power-up message is 32 spaces, shown if text mode on undefined.
// - indefinite block message eats rest of line; host places it last.
// - text mode 1 shows message, 0 removes it.
// - leaving remote cancels message and turns text mode off.
// - general reset leaves display state and message unchanged.
// - format and byte order apply only in exponential output format.
// - format is ASCII, single or double binary; reset gives ASCII.
// - commands accepted only as ASCII regardless of output format.
// - binary string begins with two header bytes hash and zero.
// - binary string ends with one terminator byte.
// - single element is four bytes: sign, 8 exponent, 23 fraction.
// - double element is 64 bits: sign, 11 exponent, 52 fraction.
// - byte order normal or reversed per element; reset gives reversed.
// - header sent once per conversion, never reordered.
// - ASCII output always normal order, reversed setting ignored.
module dtf_top
   import dtf_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // decoded commands (one-cycle strobes from the ASCII parser)
   input wire logic cmd_disp_en,
   input wire logic cmd_disp_val,
   input wire logic cmd_text_state,
   input wire logic cmd_text_val,
   input wire logic cmd_format,
   input wire logic [1:0] cmd_format_val,
   input wire logic cmd_border,
   input wire logic cmd_border_swap,
   input wire logic cmd_reset,
   input wire logic go_local,
   // message characters
   input wire logic msg_start,
   input wire logic msg_char_vld,
   input wire logic [7:0] msg_char,
   input wire logic msg_end,
   // front panel
   input wire logic [7:0] panel_keys,
   input wire logic local_key,
   output logic [7:0] panel_keys_ok,
   output logic local_req,
   // display read-out
   input wire logic [4:0] disp_idx,
   output logic disp_blank,
   output logic text_show,
   output logic [7:0] text_char,
   output logic disp_en,
   output logic text_on,
   // setup status
   input wire logic exp_format,
   output logic [1:0] fmt_eff,
   output logic swap_eff,
   // reading source
   input wire logic conv_start,
   input wire logic elem_vld,
   input wire logic elem_last,
   input wire logic [63:0] elem_data,
   input wire logic [7:0] term_char,
   output logic elem_ready,
   // byte output to bus talker
   input wire logic out_ready,
   output logic out_valid,
   output logic [7:0] out_data,
   output logic out_busy
);
   logic disp_en_r;
   logic text_on_r;
   logic [1:0] fmt_r;
   logic swap_r;
   dtf_state_e state_r;
   logic [63:0] elem_r;
   logic last_r;
   logic hdr_idx_r;
   logic [2:0] byte_idx_r;
   logic [7:0] out_data_r;
   logic out_valid_r;
   logic bin_dbl_r;
   logic swap_lat_r;
   logic [7:0] sel_byte;
   logic too_long;
   logic leave_remote;
   logic bin_sel;
   logic out_take;
   logic [2:0] elem_last_idx;
   logic [8:0] pin_s1_r;
   logic [8:0] pin_s2_r;
   logic [8:0] pin_s3_r;
   logic [8:0] pin_lvl_r;

   // true while a binary reading format is in force
   function automatic logic fmt_is_bin(input logic [1:0] fmt);
      return fmt != FMT_ASCII;
   endfunction

   // front-panel pins cross in through three stages: local key on top, keys below
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pin_s1_r <= 9'h000;
         pin_s2_r <= 9'h000;
         pin_s3_r <= 9'h000;
      end else begin
         pin_s1_r <= {local_key, panel_keys};
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   // settled pin levels; a bit moves only once its second and third stages agree
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) pin_lvl_r <= 9'h000;
      else pin_lvl_r <= (pin_s2_r & pin_s3_r) | (pin_lvl_r & (pin_s2_r | pin_s3_r));
   end

   // local key acts only once its pin has settled; a bus go-to-local acts at once
   assign leave_remote = go_local | pin_lvl_r[8];

   // display enable: power-up on, reset command has no effect
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) disp_en_r <= DISP_EN_RST;
      else if (leave_remote) disp_en_r <= 1'b1;
      else if (cmd_disp_en) disp_en_r <= cmd_disp_val;
   end

   // text mode: leaving remote turns it off and cancels the message
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) text_on_r <= TEXT_ON_RST;
      else if (leave_remote) text_on_r <= 1'b0;
      else if (cmd_text_state) text_on_r <= cmd_text_val;
   end

   // message store; cleared on leaving remote, kept over reset command
   dtf_msg_store u_msg (
      .mclk(mclk),
      .rst(rst),
      .load_start(msg_start), // block end comes from parser line end
      .load_char_vld(msg_char_vld),
      .load_char(msg_char),
      .load_end(msg_end),
      .clear(leave_remote),
      .rd_idx(disp_idx),
      .rd_char(text_char),
      .too_long(too_long)
   );

   // display outputs
   assign disp_en = disp_en_r;
   assign text_on = text_on_r;
   assign disp_blank = ~disp_en_r;
   assign text_show = text_on_r & ~too_long & disp_en_r;
   assign panel_keys_ok = disp_en_r ? pin_lvl_r[7:0] : 8'h00;
   // the local key stays live whatever the display shows
   assign local_req = pin_lvl_r[8];

   // format and order settings, reset command restores defaults
   // a format code of 3 names no format and is refused
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         fmt_r <= FMT_RST;
         swap_r <= ORDER_SWAP_RST;
      end else if (cmd_reset) begin
         fmt_r <= FMT_RST;
         swap_r <= ORDER_SWAP_RST;
      end else begin
         if (cmd_format && cmd_format_val != 2'h3) fmt_r <= cmd_format_val;
         if (cmd_border) swap_r <= cmd_border_swap;
      end
   end

   // settings take effect only in exponential format; ASCII never swapped
   assign fmt_eff = exp_format ? fmt_r : FMT_ASCII;
   assign swap_eff = fmt_is_bin(fmt_eff) & swap_r;
   assign bin_sel = fmt_is_bin(fmt_eff);

   dtf_byte_sel u_sel (
      .elem(elem_r),
      .dbl(bin_dbl_r),
      .swap(swap_lat_r),
      .idx(byte_idx_r),
      .byte_out(sel_byte)
   );

   assign elem_last_idx = bin_dbl_r ? 3'(DBL_BYTES - 4'h1) : 3'(SGL_BYTES - 4'h1);
   assign out_take = out_valid_r & out_ready;
   assign elem_ready = (state_r == st_wait);

   // binary string sequencer: header, elements, terminator
   // layout and order are latched at the start so a setting change cannot tear a string
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_r <= st_idle;
         hdr_idx_r <= 1'b0;
         byte_idx_r <= 3'h0;
         elem_r <= 64'h0;
         last_r <= 1'b0;
         bin_dbl_r <= 1'b0;
         swap_lat_r <= 1'b0;
      end else begin
         case (state_r)
            st_idle: begin
               if (conv_start && bin_sel) begin
                  bin_dbl_r <= (fmt_eff == FMT_DOUBLE);
                  swap_lat_r <= swap_eff;
                  hdr_idx_r <= 1'b0;
                  state_r <= st_hdr;
               end
            end
            st_hdr: begin
               if (out_take) begin
                  hdr_idx_r <= 1'b1;
                  if (hdr_idx_r) state_r <= st_wait;
               end
            end
            st_wait: begin
               if (elem_vld) begin
                  elem_r <= elem_data;
                  last_r <= elem_last;
                  byte_idx_r <= 3'h0;
                  state_r <= st_elem;
               end
            end
            st_elem: begin
               if (out_take) begin
                  byte_idx_r <= byte_idx_r + 3'h1;
                  if (byte_idx_r == elem_last_idx) begin
                     state_r <= last_r ? st_term : st_wait;
                  end
               end
            end
            st_term: begin
               if (out_take) state_r <= st_idle;
            end
            default: state_r <= st_idle;
         endcase
      end
   end

   // output byte register; header is fixed order regardless of swap
   // valid drops for at least one cycle after each take while the register reloads, except between the two header bytes
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         out_valid_r <= 1'b0;
         out_data_r <= 8'h00;
      end else begin
         out_valid_r <= 1'b0;
         case (state_r)
            st_hdr: begin
               if (!(out_take && hdr_idx_r)) begin
                  out_valid_r <= 1'b1;
                  if (out_take) out_data_r <= CHR_ZERO;
                  else out_data_r <= hdr_idx_r ? CHR_ZERO : CHR_HASH;
               end
            end
            st_elem: begin
               out_valid_r <= 1'b1;
               out_data_r <= sel_byte;
               if (out_take) out_valid_r <= 1'b0;
            end
            st_term: begin
               out_valid_r <= ~out_take;
               out_data_r <= term_char;
            end
            default: out_valid_r <= 1'b0;
         endcase
      end
   end

   assign out_valid = out_valid_r;
   assign out_data = out_data_r;
   assign out_busy = (state_r != st_idle);

   // assertions: display and message
   a_blank_follows_en: assert property (@(posedge mclk) disable iff (rst)
      disp_blank == !disp_en_r) else $error("blank does not follow enable");
   a_panel_gated: assert property (@(posedge mclk) disable iff (rst)
      !disp_en_r |-> panel_keys_ok == 8'h00) else $error("panel key passed while display off");
   a_disp_cmd_sets: assert property (@(posedge mclk) disable iff (rst)
      (cmd_disp_en && !leave_remote) |=> disp_en_r == $past(cmd_disp_val))
      else $error("display command not applied");
   a_text_cmd_sets: assert property (@(posedge mclk) disable iff (rst)
      (cmd_text_state && !leave_remote) |=> text_on_r == $past(cmd_text_val))
      else $error("text mode command not applied");
   a_local_kills_text: assert property (@(posedge mclk) disable iff (rst)
      leave_remote |=> !text_on_r) else $error("text mode survives local");
   a_local_restores: assert property (@(posedge mclk) disable iff (rst)
      leave_remote |=> disp_en_r) else $error("display not restored by local");
   a_text_needs_fit: assert property (@(posedge mclk) disable iff (rst)
      too_long |-> !text_show) else $error("overlong message shown");
   a_reset_keeps_disp: assert property (@(posedge mclk) disable iff (rst)
      (cmd_reset && !cmd_disp_en && !leave_remote) |=> $stable(disp_en_r))
      else $error("reset command changed display");
   a_reset_keeps_text: assert property (@(posedge mclk) disable iff (rst)
      (cmd_reset && !cmd_text_state && !leave_remote) |=> $stable(text_on_r))
      else $error("reset command changed text mode");

   // assertions: reading formatter
   a_reset_fmt_ascii: assert property (@(posedge mclk) disable iff (rst)
      cmd_reset |=> (fmt_r == FMT_ASCII && swap_r)) else $error("reset defaults wrong");
   a_fmt_refused: assert property (@(posedge mclk) disable iff (rst)
      (cmd_format && cmd_format_val == 2'h3 && !cmd_reset) |=> $stable(fmt_r))
      else $error("unused format code accepted");
   a_ascii_no_swap: assert property (@(posedge mclk) disable iff (rst)
      (fmt_eff == FMT_ASCII) |-> !swap_eff) else $error("swap active in ASCII");
   a_noexp_ascii: assert property (@(posedge mclk) disable iff (rst)
      !exp_format |-> fmt_eff == FMT_ASCII) else $error("format active without exponential");
   a_ascii_no_start: assert property (@(posedge mclk) disable iff (rst)
      (state_r == st_idle && conv_start && !bin_sel) |=> state_r == st_idle)
      else $error("binary string started in ASCII");
   a_hdr_hash_first: assert property (@(posedge mclk) disable iff (rst)
      (state_r == st_idle && conv_start && bin_sel) |=> ##1 (out_valid && out_data == CHR_HASH))
      else $error("header does not start with hash");
   a_hdr_zero_next: assert property (@(posedge mclk) disable iff (rst)
      (state_r == st_hdr && out_take && !hdr_idx_r) |=> (out_valid && out_data == CHR_ZERO))
      else $error("header second byte not zero");
   a_order_latched: assert property (@(posedge mclk) disable iff (rst)
      (out_busy && $past(out_busy)) |-> ($stable(swap_lat_r) && $stable(bin_dbl_r)))
      else $error("byte order changed inside a string");
   a_out_holds: assert property (@(posedge mclk) disable iff (rst)
      (out_valid && !out_ready && state_r != st_term) |=> (out_valid && $stable(out_data)))
      else $error("byte dropped before taken");
   a_wait_quiet: assert property (@(posedge mclk) disable iff (rst)
      (state_r == st_wait || state_r == st_idle) |-> !out_valid) else $error("filler byte sent");
   a_term_one_byte: assert property (@(posedge mclk) disable iff (rst)
      (state_r == st_term && out_take) |=> state_r == st_idle) else $error("terminator repeated");
   a_term_data: assert property (@(posedge mclk) disable iff (rst)
      (state_r == st_term && out_valid) |-> out_data == term_char) else $error("terminator byte wrong");
endmodule // dtf_top
`default_nettype wire

//--- verification/dtf_host_model.sv
// dtf_host_model: host computer reading reading bytes from the bus talker
// assumes out_valid/out_data stand until taken; slow mode stalls two of three cycles
`timescale 1ns/10ps
`default_nettype none
module dtf_host_model (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // byte stream from the formatter
   input wire logic out_valid,
   input wire logic [7:0] out_data,
   output logic out_ready,
   // pacing control from the bench
   input wire logic slow
);
   logic [7:0] rx_q[$];
   logic [1:0] pace_r;
   // pacing counter, changed away from the sampling edge
   always @(negedge mclk or posedge rst) begin
      if (rst) begin
         pace_r <= 2'h0;
      end else begin
         pace_r <= (pace_r == 2'h2) ? 2'h0 : pace_r + 2'h1;
      end
   end
   // host stays addressed to talk and keeps reading until the string ends
   assign out_ready = slow ? (pace_r == 2'h0) : 1'b1;
   // collect each accepted byte in arrival order
   always @(posedge mclk) begin
      if (!rst && out_valid === 1'b1 && out_ready) begin
         rx_q.push_back(out_data);
      end
   end
endmodule // dtf_host_model
`default_nettype wire

//--- verification/tb_dtf_top.sv
// tb_dtf_top: self-checking bench for display control and reading formatter
// assumes dtf_top and dtf_host_model compiled before; inputs change at falling edge
`timescale 1ns/10ps
`default_nettype none
module tb_dtf_top;
   import dtf_pkg::*;
   logic mclk = 0, rst = 1, slow = 0;
   logic cmd_disp_en = 0, cmd_disp_val = 0, cmd_text_state = 0, cmd_text_val = 0;
   logic cmd_format = 0, cmd_border = 0, cmd_border_swap = 0, cmd_reset = 0, go_local = 0;
   logic [1:0] cmd_format_val = 2'h0;
   logic msg_start = 0, msg_char_vld = 0, msg_end = 0, local_key = 0, local_req, exp_format = 1;
   logic [7:0] msg_char = 8'h00, panel_keys = 8'hA5, panel_keys_ok, text_char, out_data;
   logic [7:0] term_char = 8'h5A;
   logic [4:0] disp_idx = 5'h00;
   logic disp_blank, text_show, disp_en, text_on, swap_eff, elem_ready, out_ready, out_valid, out_busy;
   logic conv_start = 0, elem_vld = 0, elem_last = 0;
   logic [63:0] elem_data = 64'h0;
   logic [1:0] fmt_eff;
   logic [63:0] ev [2] = '{64'h0123456789ABCDEF, 64'hFEDCBA9876543210};
   int fail_count = 0, n_compared = 0;
   // clock of 100 ns period
   always #50 mclk = ~mclk;
   dtf_top dut (.mclk(mclk), .rst(rst), .cmd_disp_en(cmd_disp_en), .cmd_disp_val(cmd_disp_val),
      .cmd_text_state(cmd_text_state), .cmd_text_val(cmd_text_val), .cmd_format(cmd_format),
      .cmd_format_val(cmd_format_val), .cmd_border(cmd_border), .cmd_border_swap(cmd_border_swap),
      .cmd_reset(cmd_reset), .go_local(go_local), .msg_start(msg_start), .msg_char_vld(msg_char_vld),
      .msg_char(msg_char), .msg_end(msg_end), .panel_keys(panel_keys), .local_key(local_key),
      .panel_keys_ok(panel_keys_ok), .local_req(local_req), .disp_idx(disp_idx),
      .disp_blank(disp_blank), .text_show(text_show), .text_char(text_char), .disp_en(disp_en),
      .text_on(text_on), .exp_format(exp_format), .fmt_eff(fmt_eff), .swap_eff(swap_eff),
      .conv_start(conv_start), .elem_vld(elem_vld), .elem_last(elem_last), .elem_data(elem_data),
      .term_char(term_char), .elem_ready(elem_ready), .out_ready(out_ready), .out_valid(out_valid),
      .out_data(out_data), .out_busy(out_busy));
   dtf_host_model host (.mclk(mclk), .rst(rst), .out_valid(out_valid), .out_data(out_data),
      .out_ready(out_ready), .slow(slow));
   // count and report one comparison
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // print counts and verdict, then stop
   task give_verdict();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // one-cycle command strobe with its value; commands reach us already decoded from ASCII
   task cmd(input int k, input logic [1:0] v);
      @(negedge mclk);
      case (k)
         0: begin cmd_disp_en = 1; cmd_disp_val = v[0]; end
         1: begin cmd_text_state = 1; cmd_text_val = v[0]; end
         2: begin cmd_format = 1; cmd_format_val = v; end
         3: begin cmd_border = 1; cmd_border_swap = v[0]; end
         4: cmd_reset = 1;
         default: go_local = 1;
      endcase
      @(negedge mclk);
      {cmd_disp_en, cmd_text_state, cmd_format, cmd_border, cmd_reset, go_local} = '0;
   endtask
   // message of n characters counting up from c0; the block stands last on its line
   task load_msg(input int n, input logic [7:0] c0);
      @(negedge mclk);
      msg_start = 1;
      for (int i = 0; i < n; i++) begin
         @(negedge mclk);
         msg_start = 0;
         msg_char_vld = 1;
         msg_char = c0 + 8'(i);
      end
      @(negedge mclk);
      msg_char_vld = 0;
      msg_end = 1;
      @(negedge mclk);
      msg_end = 0;
   endtask
   // read the whole stored message back, padding expected as spaces
   task chk_msg(input int n, input logic [7:0] c0);
      for (int i = 0; i < 32; i++) begin
         disp_idx = 5'(i);
         #1;
         chk(text_char, (i < n) ? c0 + 8'(i) : CHR_SPACE);
      end
   endtask
   // wait on a flag with a bound; a bound used up ends the run
   task wait_flag(input int k);
      int i;
      for (i = 0; i < 400; i++) begin
         @(negedge mclk);
         if ((k == 0 && elem_ready === 1'b1) || (k == 1 && out_busy === 1'b0)) break;
      end
      if (i == 400) begin
         fail_count++;
         give_verdict();
      end
   endtask
   // one binary conversion string of two elements, checked byte for byte
   task run_conv(input logic [1:0] fmt, input logic sw);
      logic [7:0] exp_q[$];
      int nb;
      nb = (fmt == FMT_SINGLE) ? 4 : 8;
      cmd(2, fmt);
      cmd(3, {1'b0, sw});
      host.rx_q.delete();
      slow = sw;
      conv_start = 1;
      @(negedge mclk);
      conv_start = 0;
      for (int e = 0; e < 2; e++) begin
         wait_flag(0);
         elem_vld = 1;
         elem_last = (e == 1);
         elem_data = ev[e];
         @(negedge mclk);
         elem_vld = 0;
      end
      wait_flag(1);
      exp_q = '{CHR_HASH, CHR_ZERO};
      foreach (ev[e]) for (int b = 0; b < nb; b++) exp_q.push_back(ev[e][8 * (sw ? b : nb - 1 - b) +: 8]);
      exp_q.push_back(term_char);
      chk(8'(host.rx_q.size()), 8'(exp_q.size()));
      foreach (exp_q[i]) chk(host.rx_q[i], exp_q[i]);
   endtask
   // main sequence
   initial begin
      repeat (16) @(negedge mclk);
      rst = 0;
      @(negedge mclk);
      chk(disp_en, DISP_EN_RST);
      chk(text_on, TEXT_ON_RST);
      chk(fmt_eff, FMT_RST);
      chk(swap_eff, 1'b0);
      chk_msg(0, CHR_SPACE);
      repeat (3) @(negedge mclk);
      chk(panel_keys_ok, 8'hA5);
      cmd(0, 2'h0);
      chk(disp_blank, 1'b1);
      chk(panel_keys_ok, 8'h00);
      local_key = 1;
      repeat (4) @(negedge mclk);
      chk(local_req, 1'b1);
      local_key = 0;
      repeat (5) @(negedge mclk);
      chk(disp_en, 1'b1);
      chk(local_req, 1'b0);
      cmd(0, 2'h0);
      cmd(0, 2'h1);
      chk(disp_en, 1'b1);
      load_msg(2, 8'h41);
      chk_msg(2, 8'h41);
      cmd(1, 2'h1);
      chk(text_show, 1'b1);
      cmd(4, 2'h0);
      chk(text_on, 1'b1);
      chk(disp_en, 1'b1);
      chk_msg(2, 8'h41);
      cmd(1, 2'h0);
      chk(text_show, 1'b0);
      cmd(1, 2'h1);
      cmd(5, 2'h0);
      chk(text_on, 1'b0);
      chk_msg(0, CHR_SPACE);
      load_msg(33, 8'h41);
      cmd(1, 2'h1);
      chk(text_show, 1'b0);
      load_msg(32, 8'h30);
      chk(text_show, 1'b1);
      chk_msg(32, 8'h30);
      cmd(2, FMT_SINGLE);
      exp_format = 0;
      #1 chk(fmt_eff, FMT_ASCII);
      exp_format = 1;
      #1 chk(fmt_eff, FMT_SINGLE);
      chk(swap_eff, ORDER_SWAP_RST);
      cmd(2, 2'h3);
      chk(fmt_eff, FMT_SINGLE);
      cmd(2, FMT_ASCII);
      cmd(3, 2'h1);
      chk(swap_eff, 1'b0);
      conv_start = 1;
      @(negedge mclk);
      conv_start = 0;
      repeat (8) @(negedge mclk);
      chk(8'(host.rx_q.size()), 8'h00);
      for (int f = 1; f < 3; f++) for (int s = 0; s < 2; s++) run_conv(2'(f), s[0]);
      cmd(4, 2'h0);
      chk(fmt_eff, FMT_RST);
      chk(swap_eff, 1'b0);
      give_verdict();
   end
endmodule // tb_dtf_top
`default_nettype wire
